// >>> rtl/rbx_pkg.sv
// Package for the relative branch and bit-set execution block.
// Holds opcode patterns, field positions, address-split constants and state types.
// Assumes a 16-bit instruction word and a 12-bit file register address space.
package rbx_pkg;

  // Instruction word and field layout.
  localparam int INSTR_W       = 16;
  localparam int BR_OFF_W      = 11;
  localparam int BR_OPC_LSB    = 11;
  localparam int BS_OPC_LSB    = 12;
  localparam int BS_BIT_LSB    = 9;
  localparam int BS_ACC_POS    = 8;
  localparam int FREG_W        = 8;
  localparam int BIT_POS_W     = 3;
  localparam int DATA_W        = 8;
  localparam int BANK_W        = 4;
  localparam int FADDR_W       = 12;

  // Opcode patterns in the top bits of the word.
  localparam logic [4:0] OPC_UNCOND_REL_BRANCH = 5'h1A;
  localparam logic [3:0] OPC_FILE_BIT_SET      = 4'h8;

  // Access-bank split: low part maps to bank 0, high part to the top bank.
  localparam logic [7:0]  ACCESS_LOW_LIMIT = 8'h5F;
  localparam logic [3:0]  ACCESS_LO_BANK   = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK   = 4'hF;

  // Instruction cycles taken by the branch.
  localparam int BRANCH_CYCLES = 2;

  // Quarter phase of an instruction cycle.
  typedef enum logic [1:0] {
    RBX_Q1 = 2'b00,
    RBX_Q2 = 2'b01,
    RBX_Q3 = 2'b10,
    RBX_Q4 = 2'b11
  } rbx_quarter_t;

  // Cycle state: executing, or the forced empty cycle after a branch.
  typedef enum logic [0:0] {
    RBX_ST_RUN = 1'b0,
    RBX_ST_NOP = 1'b1
  } rbx_state_t;

  // Kind of instruction held in the current cycle.
  typedef enum logic [1:0] {
    RBX_K_NONE = 2'b00,
    RBX_K_BRA  = 2'b01,
    RBX_K_BSF  = 2'b10
  } rbx_kind_t;

endpackage

// >>> rtl/rbx_bit_if.sv
// Interface joining the execution top to its bit-set address unit.
// Assumes both ends sit on the same clock; the carried signals are combinational.
`timescale 1ns/1ps
`default_nettype none

interface rbx_bit_if;
  logic [rbx_pkg::FREG_W-1:0]    f_addr;
  logic                          access_sel;
  logic [rbx_pkg::BIT_POS_W-1:0] bit_pos;
  logic                          ext_en;
  logic [rbx_pkg::BANK_W-1:0]    bank;
  logic [rbx_pkg::FADDR_W-1:0]   index_base;
  logic [rbx_pkg::FADDR_W-1:0]   eff_addr;
  logic [rbx_pkg::DATA_W-1:0]    set_mask;
  logic                          indexed;

  modport req (
    output f_addr, access_sel, bit_pos, ext_en, bank, index_base,
    input  eff_addr, set_mask, indexed
  );
  modport rsv (
    input  f_addr, access_sel, bit_pos, ext_en, bank, index_base,
    output eff_addr, set_mask, indexed
  );
endinterface

`default_nettype wire

// >>> rtl/rbx_bit_addr.sv
// Bit-set address unit: resolves the file register address and the bit mask.
// Assumes the request fields are stable during the decode quarter.
`timescale 1ns/1ps
`default_nettype none

module rbx_bit_addr (
  rbx_bit_if.rsv bif
);

  // Address selection: banked, indexed literal offset, or split access bank.
  always_comb begin
    bif.indexed = 1'b0;
    if (bif.access_sel) begin
      bif.eff_addr = {bif.bank, bif.f_addr};
    end else if (bif.ext_en && (bif.f_addr <= rbx_pkg::ACCESS_LOW_LIMIT)) begin
      // The offset wraps inside the address space, as the pointer itself does.
      bif.indexed  = 1'b1; // see [RULE_06]
      bif.eff_addr = bif.index_base + {{(rbx_pkg::FADDR_W-rbx_pkg::FREG_W){1'b0}}, bif.f_addr};
    end else if (bif.f_addr <= rbx_pkg::ACCESS_LOW_LIMIT) begin
      bif.eff_addr = {rbx_pkg::ACCESS_LO_BANK, bif.f_addr};
    end else begin
      bif.eff_addr = {rbx_pkg::ACCESS_HI_BANK, bif.f_addr};
    end
  end

  // One-hot mask for the selected bit position.
  genvar gi;
  generate
    for (gi = 0; gi < rbx_pkg::DATA_W; gi++) begin : g_mask
      assign bif.set_mask[gi] = (bif.bit_pos == rbx_pkg::BIT_POS_W'(gi)); // see [RULE_05]
    end
  endgenerate

endmodule

`default_nettype wire

// >>> rtl/rbx_exec.sv
// Execution top for the unconditional relative branch and the file bit-set.
// Assumes the fetch stream presents one instruction word during quarter Q1,
// and that the file register read port answers within the same clock.
//
// Behaviour
// [RULE_01] Branch target is incremented address plus twice offset.
// [RULE_02] Offset is signed 11-bit, sign-extended then doubled.
// [RULE_03] Branch takes two cycles; second is empty.
// [RULE_04] Bit-set forces one bit, single cycle, flags untouched.
// [RULE_05] Bit-set carries address, bit position, bank select.
// [RULE_06] Extended set indexes low access addresses.
// [RULE_07] Decode branch by 11010, bit-set by 1000.
`timescale 1ns/1ps
`default_nettype none

module rbx_exec #(
  parameter int PC_W = 21
) (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_instr_valid,
  input  wire logic [rbx_pkg::INSTR_W-1:0]  i_instr,
  input  wire logic [PC_W-1:0]              i_pc_inc,
  input  wire logic                         i_ext_en,
  input  wire logic [rbx_pkg::BANK_W-1:0]   i_bank_select_reg,
  input  wire logic [rbx_pkg::FADDR_W-1:0]  i_index_base,
  input  wire logic [rbx_pkg::DATA_W-1:0]   i_file_rdata,
  output logic [1:0]                        o_quarter,
  output logic                              o_instr_taken,
  output logic                              o_pc_load,
  output logic [PC_W-1:0]                   o_pc_target,
  output logic                              o_file_re,
  output logic                              o_file_we,
  output logic [rbx_pkg::FADDR_W-1:0]       o_file_addr,
  output logic [rbx_pkg::DATA_W-1:0]        o_file_wdata,
  output logic                              o_indexed,
  output logic                              o_nop_cycle
);

  rbx_bit_if bif ();

  rbx_pkg::rbx_quarter_t         q;
  rbx_pkg::rbx_quarter_t         next_q;
  rbx_pkg::rbx_state_t           st;
  rbx_pkg::rbx_state_t           next_st;
  rbx_pkg::rbx_kind_t            kind;
  rbx_pkg::rbx_kind_t            next_kind;
  logic [PC_W-1:0]               pc_base;
  logic [PC_W-1:0]               next_pc_base;
  logic [PC_W-1:0]               offset_ext;
  logic [PC_W-1:0]               next_offset_ext;
  logic [rbx_pkg::DATA_W-1:0]    mask;
  logic [rbx_pkg::DATA_W-1:0]    next_mask;
  logic [rbx_pkg::DATA_W-1:0]    rdata;
  logic [rbx_pkg::DATA_W-1:0]    next_rdata;
  logic                          next_instr_taken;
  logic                          next_pc_load;
  logic [PC_W-1:0]               next_pc_target;
  logic                          next_file_re;
  logic                          next_file_we;
  logic [rbx_pkg::FADDR_W-1:0]   next_file_addr;
  logic [rbx_pkg::DATA_W-1:0]    next_file_wdata;
  logic                          next_indexed;
  logic                          next_nop_cycle;
  logic                          is_bra;
  logic                          is_bsf;
  logic                          take;

  // Decode straight from the fetched word so the address is ready by Q2.
  assign is_bra = (i_instr[rbx_pkg::INSTR_W-1:rbx_pkg::BR_OPC_LSB]
                   == rbx_pkg::OPC_UNCOND_REL_BRANCH); // see [RULE_07]
  assign is_bsf = (i_instr[rbx_pkg::INSTR_W-1:rbx_pkg::BS_OPC_LSB]
                   == rbx_pkg::OPC_FILE_BIT_SET); // see [RULE_07]

  // The word fetched during the branch is discarded, so nothing is taken then.
  assign take = (q == rbx_pkg::RBX_Q1) && (st == rbx_pkg::RBX_ST_RUN) && i_instr_valid;

  // Fields handed to the address unit.
  assign bif.f_addr     = i_instr[rbx_pkg::FREG_W-1:0]; // see [RULE_05]
  assign bif.access_sel = i_instr[rbx_pkg::BS_ACC_POS];
  assign bif.bit_pos    = i_instr[rbx_pkg::BS_BIT_LSB +: rbx_pkg::BIT_POS_W];
  assign bif.ext_en     = i_ext_en;
  assign bif.bank       = i_bank_select_reg;
  assign bif.index_base = i_index_base;

  rbx_bit_addr u_bit_addr (
    .bif (bif.rsv)
  );

  // Quarter counter and cycle state.
  always_comb begin
    next_q  = rbx_pkg::rbx_quarter_t'(q + 2'h1);
    next_st = st;
    case (q)
      rbx_pkg::RBX_Q4: begin
        if (st == rbx_pkg::RBX_ST_NOP) begin
          next_st = rbx_pkg::RBX_ST_RUN;
        end else if (kind == rbx_pkg::RBX_K_BRA) begin
          next_st = rbx_pkg::RBX_ST_NOP; // see [RULE_03]
        end
      end
      default: begin
        next_st = st;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q  <= rbx_pkg::RBX_Q1;
      st <= rbx_pkg::RBX_ST_RUN;
    end else begin
      q  <= next_q;
      st <= next_st;
    end
  end

  // Per-instruction working state: kind, base address, offset, mask, read data.
  always_comb begin
    next_kind       = kind;
    next_pc_base    = pc_base;
    next_offset_ext = offset_ext;
    next_mask       = mask;
    next_rdata      = rdata;
    case (q)
      rbx_pkg::RBX_Q1: begin
        next_kind = rbx_pkg::RBX_K_NONE;
        if (take && is_bra) begin
          next_kind       = rbx_pkg::RBX_K_BRA;
          next_pc_base    = i_pc_inc; // see [RULE_01]
          // Sign-extend first and double afterwards, giving an even byte offset.
          next_offset_ext = {{(PC_W-rbx_pkg::BR_OFF_W-1){i_instr[rbx_pkg::BR_OFF_W-1]}},
                             i_instr[rbx_pkg::BR_OFF_W-1:0], 1'b0}; // see [RULE_02]
        end else if (take && is_bsf) begin
          next_kind = rbx_pkg::RBX_K_BSF;
          next_mask = bif.set_mask;
        end
      end
      rbx_pkg::RBX_Q2: begin
        if (kind == rbx_pkg::RBX_K_BSF) begin
          next_rdata = i_file_rdata; // see [RULE_04]
        end
      end
      default: begin
        next_kind = kind;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      kind       <= rbx_pkg::RBX_K_NONE;
      pc_base    <= '0;
      offset_ext <= '0;
      mask       <= '0;
      rdata      <= '0;
    end else begin
      kind       <= next_kind;
      pc_base    <= next_pc_base;
      offset_ext <= next_offset_ext;
      mask       <= next_mask;
      rdata      <= next_rdata;
    end
  end

  // Port-facing outputs; each shows in the quarter after the one that computes it.
  // Nothing here touches status flags: the block has no flag outputs at all.
  always_comb begin
    next_instr_taken = 1'b0;
    next_pc_load     = 1'b0;
    next_pc_target   = o_pc_target;
    next_file_re     = 1'b0;
    next_file_we     = 1'b0;
    next_file_addr   = o_file_addr;
    next_file_wdata  = o_file_wdata;
    next_indexed     = o_indexed;
    next_nop_cycle   = o_nop_cycle;
    case (q)
      rbx_pkg::RBX_Q1: begin
        next_instr_taken = take;
        if (take && is_bsf) begin
          next_file_re   = 1'b1; // see [RULE_04]
          next_file_addr = bif.eff_addr; // see [RULE_06]
          next_indexed   = bif.indexed;
        end
      end
      rbx_pkg::RBX_Q3: begin
        if (kind == rbx_pkg::RBX_K_BRA) begin
          // The write lands in Q4 of the first branch cycle.
          next_pc_load   = 1'b1; // see [RULE_03]
          next_pc_target = pc_base + offset_ext; // see [RULE_01]
        end else if (kind == rbx_pkg::RBX_K_BSF) begin
          // Only the selected bit rises; the rest pass through unchanged.
          next_file_we    = 1'b1; // see [RULE_04]
          next_file_wdata = rdata | mask; // see [RULE_04]
        end
      end
      rbx_pkg::RBX_Q4: begin
        // The empty cycle spans all four quarters after the branch cycle.
        next_nop_cycle = (st == rbx_pkg::RBX_ST_RUN) && (kind == rbx_pkg::RBX_K_BRA);
      end
      default: begin
        next_pc_load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_quarter     <= rbx_pkg::RBX_Q1;
      o_instr_taken <= 1'b0;
      o_pc_load     <= 1'b0;
      o_pc_target   <= '0;
      o_file_re     <= 1'b0;
      o_file_we     <= 1'b0;
      o_file_addr   <= '0;
      o_file_wdata  <= '0;
      o_indexed     <= 1'b0;
      o_nop_cycle   <= 1'b0;
    end else begin
      o_quarter     <= next_q;
      o_instr_taken <= next_instr_taken;
      o_pc_load     <= next_pc_load;
      o_pc_target   <= next_pc_target;
      o_file_re     <= next_file_re;
      o_file_we     <= next_file_we;
      o_file_addr   <= next_file_addr;
      o_file_wdata  <= next_file_wdata;
      o_indexed     <= next_indexed;
      o_nop_cycle   <= next_nop_cycle;
    end
  end

endmodule

`default_nettype wire

// >>> bench/rbx_exec_chk.sv
// Checker for the branch and bit-set execution block.
// Sees only the top ports and is bound into every rbx_exec.
`timescale 1ns/1ps
`default_nettype none
module rbx_exec_chk #(
  parameter int PC_W = 21
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [PC_W-1:0] i_pc_inc,
  input wire logic        i_ext_en,
  input wire logic [3:0]  i_bank_select_reg,
  input wire logic [11:0] i_index_base,
  input wire logic [7:0]  i_file_rdata,
  input wire logic [1:0]  o_quarter,
  input wire logic        o_instr_taken,
  input wire logic        o_pc_load,
  input wire logic [PC_W-1:0] o_pc_target,
  input wire logic        o_file_re,
  input wire logic        o_file_we,
  input wire logic [11:0] o_file_addr,
  input wire logic [7:0]  o_file_wdata,
  input wire logic        o_indexed,
  input wire logic        o_nop_cycle
);
  logic            take;
  logic            is_br;
  logic            is_bs;
  logic [PC_W-1:0] br_tgt;
  logic [11:0]     idx_sum;
  // Word accepted this clock; the empty cycle refuses words.
  assign take    = (o_quarter == 2'h0) && i_instr_valid && !o_nop_cycle;
  assign is_br   = take && (i_instr[15:11] == 5'h1A);
  assign is_bs   = take && (i_instr[15:12] == 4'h8);
  assign br_tgt  = i_pc_inc + {{(PC_W-12){i_instr[10]}}, i_instr[10:0], 1'b0};
  assign idx_sum = i_index_base + {4'h0, i_instr[7:0]};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_branch_load: assert property (is_br |=> o_instr_taken ##2 o_pc_load)
    else $error("Branch did not load the counter in Q4.");
  a_branch_target: assert property (is_br |-> ##3 o_pc_target == $past(br_tgt, 3))
    else $error("Branch target is wrong.");
  a_empty_cycle: assert property (o_pc_load |=> o_nop_cycle [*4] ##1 !o_nop_cycle)
    else $error("Empty cycle after a branch is not four clocks.");
  a_bit_access: assert property (is_bs |=> o_file_re ##2 (o_file_we && !o_pc_load))
    else $error("Bit-set read or write out of place.");
  a_bit_wdata: assert property (is_bs |-> ##3 o_file_wdata ==
    ($past(i_file_rdata, 2) | (8'h01 << $past(i_instr[11:9], 3))))
    else $error("Bit-set write data is wrong.");
  a_bank_addr: assert property (is_bs && i_instr[8] |=>
    o_file_addr == {$past(i_bank_select_reg), $past(i_instr[7:0])})
    else $error("Banked address is wrong.");
  a_index_addr: assert property (is_bs && !i_instr[8] && i_ext_en &&
    i_instr[7:0] <= 8'h5F |=> o_indexed && o_file_addr == $past(idx_sum))
    else $error("Indexed address is wrong.");
  a_access_addr: assert property (is_bs && !i_instr[8] && !i_ext_en |=>
    !o_indexed && o_file_addr == {($past(i_instr[7:0]) > 8'h5F) ? 4'hF : 4'h0,
    $past(i_instr[7:0])})
    else $error("Access bank address is wrong.");
  // The quarter steps by one each clock; the first clock after reset is skipped,
  // because its previous sample still holds the reset value.
  a_quarter_step: assert property ($past(i_rst) == 1'b0 |->
    o_quarter == 2'($past(o_quarter) + 2'h1))
    else $error("Quarter phase did not advance by one.");
  // A word is only taken in an open Q1; the empty cycle refuses what it is offered.
  a_taken_only: assert property (o_instr_taken |-> $past(take))
    else $error("Word taken outside an open first quarter.");
endmodule

bind rbx_exec rbx_exec_chk #(.PC_W(PC_W)) u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
  .i_instr(i_instr), .i_pc_inc(i_pc_inc), .i_ext_en(i_ext_en),
  .i_bank_select_reg(i_bank_select_reg), .i_index_base(i_index_base),
  .i_file_rdata(i_file_rdata), .o_quarter(o_quarter), .o_instr_taken(o_instr_taken),
  .o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_file_re(o_file_re),
  .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
  .o_indexed(o_indexed), .o_nop_cycle(o_nop_cycle));
`default_nettype wire

// >>> bench/rbx_exec_tb.sv
// Self-checking bench for the branch and bit-set execution block.
// Drives the fetch side on falling edges and acts as the file read port.
`timescale 1ns/1ps
`default_nettype none
module rbx_exec_tb;
  localparam int PC_W = 21;
  logic            i_core_clk = 1'b0;
  logic            i_rst = 1'b1;
  logic            i_instr_valid = 1'b0;
  logic [15:0]     i_instr = 16'h0000;
  logic [PC_W-1:0] i_pc_inc = '0;
  logic            i_ext_en = 1'b0;
  logic [3:0]      i_bank_select_reg = 4'h0;
  logic [11:0]     i_index_base = 12'h000;
  logic [7:0]      i_file_rdata = 8'h00;
  logic [1:0]      o_quarter;
  logic            o_instr_taken, o_pc_load, o_file_re, o_file_we, o_indexed, o_nop_cycle;
  logic [PC_W-1:0] o_pc_target;
  logic [11:0]     o_file_addr;
  logic [7:0]      o_file_wdata;
  logic [20:0]     exp_q[$];
  int              error_cnt = 0;
  int              checked = 0;
  integer          seed = 32'h9557;

  // Free-running 200 MHz core clock.
  always #2.5 i_core_clk = ~i_core_clk;

  rbx_exec #(.PC_W(PC_W)) u_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_pc_inc(i_pc_inc), .i_ext_en(i_ext_en),
    .i_bank_select_reg(i_bank_select_reg), .i_index_base(i_index_base),
    .i_file_rdata(i_file_rdata), .o_quarter(o_quarter), .o_instr_taken(o_instr_taken),
    .o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_file_re(o_file_re),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
    .o_indexed(o_indexed), .o_nop_cycle(o_nop_cycle));

  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Compares %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Waits for an open Q1; a word offered in an empty cycle must be ignored.
  task automatic wait_q1;
    int n;
    n = 0;
    while (o_quarter !== 2'h0 || o_nop_cycle !== 1'b0) begin
      i_instr_valid <= (o_quarter === 2'h0);
      i_instr <= 16'h80FF;
      n++;
      if (n > 40) begin
        error_cnt++;
        $display("MISMATCH at %0t: no open fetch slot", $time);
        wrap_up();
      end
      @(negedge i_core_clk);
    end
  endtask

  // Each completed result is compared with the oldest note.
  always @(negedge i_core_clk) begin
    if (o_pc_load === 1'b1 || o_file_we === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("MISMATCH at %0t: result with no note", $time);
      end else if (o_pc_load === 1'b1) begin
        check(o_pc_target, exp_q.pop_front());
      end else begin
        check({o_indexed, o_file_addr, o_file_wdata}, exp_q.pop_front());
      end
    end
  end

  // Random mix of branches, bit-sets and foreign opcodes, with edge fields.
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    logic [10:0] n;
    logic [7:0]  f;
    logic [7:0]  rd;
    logic [11:0] base;
    logic [11:0] ad;
    logic [PC_W-1:0] pc;
    logic        idx;
    int          k;
    repeat (8) @(negedge i_core_clk);
    i_rst <= 1'b0;
    for (k = 0; k < 80; k++) begin
      wait_q1();
      r = $random(seed);
      pc = PC_W'($random(seed));
      base = 12'($random(seed));
      rd = r[24:17];
      f = k[0] ? r[7:0] : (8'h5F + 8'(k[1]));
      n = (k[2:1] == 2'h0) ? 11'h400 : (k[2:1] == 2'h1) ? 11'h3FF : r[10:0];
      i_pc_inc <= pc;
      i_ext_en <= r[29];
      i_bank_select_reg <= r[28:25];
      i_index_base <= base;
      i_file_rdata <= rd;
      i_instr_valid <= 1'b1;
      if (r[31:30] == 2'h2) begin
        w = {5'h1A, n};
        exp_q.push_back(pc + {{9{n[10]}}, n, 1'b0});
      end else if (r[31:30] == 2'h3) begin
        w = {4'hF, r[11:0]};
      end else begin
        w = {4'h8, r[11:8], f};
        idx = !w[8] && r[29] && f <= 8'h5F;
        ad = w[8] ? {r[28:25], f} : idx ? base + {4'h0, f} : {(f > 8'h5F) ? 4'hF : 4'h0, f};
        exp_q.push_back({idx, ad, rd | (8'h01 << w[11:9])});
      end
      i_instr <= w;
      // The fetch wait lowers the valid flag on its first pass, one driver per step.
      @(negedge i_core_clk);
      if (k == 50) begin
        i_rst <= 1'b1;
        exp_q.delete();
        repeat (2) @(negedge i_core_clk);
        i_rst <= 1'b0;
      end
    end
    i_instr_valid <= 1'b0;
    repeat (12) @(negedge i_core_clk);
    check(21'(exp_q.size()), 21'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
